// ---- tb_top.sv ----
// tb_top: self-checking bench for the video timer core
// assumes a 40 MHz clock; host writes and carries change on the falling edge
`timescale 1ns/1ps
module tb_top;
    import vt_pkg::*;
    logic       mclk, rst_n, cs_n, ds_n, carry, cur, run;  // bench wires
    logic [3:0] sel, scan;                                   // select, scan
    logic [7:0] data, col;                                   // data, column
    logic [5:0] row;                                         // data row
    int         mismatches, comparisons, cycles;             // bookkeeping
    // 4 chars/line, 3 scans/row, 4 rows, 262 lines, start at line 5
    logic [7:0] cfg [0:6] = '{8'h03, 8'h00, 8'h10, 8'h03, 8'h03, 8'h05, 8'h03};

    vt_video_timer u_dut (.I_MCLK(mclk), .I_RSTN(rst_n), .I_CS_N(cs_n), .I_DS_N(ds_n),
        .I_SEL(sel), .I_DATA(data), .I_CHAR_CLOCK_CARRY_IN(carry), .O_CHAR_COL(col),
        .O_SCAN_LINE(scan), .O_DATA_ROW(row), .O_CURSOR_VIDEO_OUT(cur), .O_RUNNING(run));

    // two cycles per character keeps the run short
    vt_dot_counter_model #(.DOTS(2)) u_dots (.i_clk(mclk), .i_rst_n(rst_n), .o_carry(carry));

    // free-running clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // hang guard, counted as a failure
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    // compare and count
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one host write; strobe high again before the next one
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(negedge mclk);
        cs_n = 1'b0;
        ds_n = 1'b0;
        sel  = s;
        data = d;
        @(negedge mclk);
        cs_n = 1'b1;
        ds_n = 1'b1;
    endtask

    // restart, count lines up to the data start, check the top row
    task automatic go(input logic [5:0] top);
        logic [7:0] prev;
        int         lines;
        lines = 0;
        wr(VT_SEL_START, 8'h00);
        @(negedge mclk);
        chk("running", 10'h001, 10'(run));
        prev = col;
        for (int n = 0; n < 400 && lines < int'(cfg[5]); n++)
        begin
            @(negedge mclk);
            if (col < prev)
            begin
                lines++;
                chk("line length", 10'(cfg[0]), 10'(prev));
            end
            prev = col;
        end
        chk("lines to data", 10'(cfg[5]), 10'(lines));
        chk("top row", 10'(top), 10'(row));
        chk("top scan", 10'h000, 10'(scan));
    endtask

    // documented power-up order, cursor at upper left
    task automatic power_up();
        // no refresh memory here, nothing to clear
        wr(VT_SEL_START, 8'h00);
        wr(VT_SEL_RESET, 8'h00);
        for (int i = 0; i < VT_NUM_CFG; i++)
            wr(4'(i), cfg[i]);
        wr(VT_SEL_CUR_COL, 8'h00);
        wr(VT_SEL_CUR_ROW, 8'h00);
        go(6'h00);
        @(negedge mclk);
        chk("cursor upper left", 10'h001, 10'(cur));
    endtask

    // cursor away from the origin, found at its column and row
    task automatic cursor_pos();
        int n;
        wr(VT_SEL_CUR_COL, 8'h02);
        wr(VT_SEL_CUR_ROW, 8'h02);
        go(6'h00);
        for (n = 0; n < 400 && cur !== 1'b1; n++)
            @(negedge mclk);
        chk("cursor col", 10'h002, 10'(col));
        chk("cursor row", 10'h002, 10'(row));
        chk("cursor scan", 10'h000, 10'(scan));
    endtask

    // reset command stops the chain; carries then ignored
    task automatic reset_cmd();
        wr(VT_SEL_RESET, 8'h5a);
        @(negedge mclk);
        chk("stopped", 10'h000, 10'(run));
        repeat (8) @(negedge mclk);
        chk("col held", 10'h000, 10'(col));
        chk("row held", 10'h000, 10'(row));
    endtask

    // follow the data rows scan by scan to the end of the data area
    task automatic row_walk(input logic [5:0] top);
        logic [7:0] prev;
        int         k, spr, rows;
        go(top);
        spr  = int'(cfg[2][6:3]) + 1;
        rows = int'(cfg[3][5:0]) + 1;
        k    = 0;
        prev = col;
        for (int n = 0; n < 400 && k < spr * rows + 1; n++)
        begin
            @(negedge mclk);
            if (col < prev)
            begin
                k++;
                if (k < spr * rows)
                begin
                    chk("walk scan", 10'(k % spr), 10'(scan));
                    chk("walk row", 10'((int'(top) + k / spr) % rows), 10'(row));
                end
                else
                begin
                    chk("end scan", 10'h000, 10'(scan));
                    chk("end row", 10'((int'(top) + rows - 1) % rows), 10'(row));
                end
            end
            prev = col;
        end
        chk("walk lines", 10'(spr * rows + 1), 10'(k));
    endtask

    // scroll from the wrap point, a direct rewrite, then a plain scroll
    task automatic scroll_rows();
        wr(VT_SEL_SCROLL, 8'h00);
        go(6'h01);
        wr(4'(VT_CFG_LASTROW), 8'h01);
        go(6'h02);
        wr(VT_SEL_SCROLL, 8'h00);
        row_walk(6'h03);
    endtask

    // counts, verdict, end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        cs_n  = 1'b1;
        ds_n  = 1'b1;
        sel   = 4'h0;
        data  = 8'h00;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        power_up();
        cursor_pos();
        reset_cmd();
        scroll_rows();
        give_verdict();
    end
endmodule // tb_top

// ---- vt_dot_counter_model.sv ----
// vt_dot_counter_model: behavioural dot counter for the character carry
// assumes the dot clock is the system clock, changed on its falling edge
`timescale 1ns/1ps
module vt_dot_counter_model #(
    parameter int DOTS = 8  // dots per character
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // one-cycle character carry
    output logic      o_carry
);
    int cnt;  // dots counted in this character

    always @(negedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt     <= 0;
            o_carry <= 1'b0;
        end
        else
        begin
            // pulse on the last dot only, so each carry counts once
            cnt     <= (cnt == DOTS - 1) ? 0 : cnt + 1;
            o_carry <= (cnt == DOTS - 1);
        end
    end
endmodule // vt_dot_counter_model

// ---- vt_pkg.sv ----
// vt_pkg: constants and types for the crt video timing controller
// assumes a host that drives select, data and an active-low data strobe
package vt_pkg;

    // select codes presented on the select lines
    localparam logic [3:0] VT_SEL_REG_LAST = 4'h6;  // config registers 0..6
    localparam logic [3:0] VT_SEL_RESET    = 4'ha;  // reset command
    localparam logic [3:0] VT_SEL_SCROLL   = 4'hb;  // scroll up one row
    localparam logic [3:0] VT_SEL_CUR_COL  = 4'hc;  // cursor character column
    localparam logic [3:0] VT_SEL_CUR_ROW  = 4'hd;  // cursor data row
    localparam logic [3:0] VT_SEL_START    = 4'he;  // start timing chain

    // number of format control registers
    localparam int VT_NUM_CFG = 7;

    // config register indices
    localparam int VT_CFG_HTOTAL  = 0;  // character times per line minus one
    localparam int VT_CFG_ROWFMT  = 2;  // scans per data row field
    localparam int VT_CFG_ROWS    = 3;  // data rows per frame field
    localparam int VT_CFG_FRAME   = 4;  // scans per frame field
    localparam int VT_CFG_VSTART  = 5;  // vertical data start
    localparam int VT_CFG_LASTROW = 6;  // last displayed data row

    // field positions
    localparam int VT_SPR_LSB  = 3;  // scans per row minus one, bits 6:3
    localparam int VT_SPR_MSB  = 6;
    localparam int VT_ROWS_MSB = 5;  // rows per frame minus one, bits 5:0

    // scans per frame is twice the field plus this base
    localparam logic [9:0] VT_FRAME_BASE = 10'h100;

    // reset values
    localparam logic [7:0] VT_CFG_RST  = 8'h00;
    localparam logic [7:0] VT_CUR_RST  = 8'h00;
    localparam logic [7:0] VT_H_RST    = 8'h00;
    localparam logic [9:0] VT_LINE_RST = 10'h000;
    localparam logic [3:0] VT_SCAN_RST = 4'h0;
    localparam logic [5:0] VT_ROW_RST  = 6'h00;

    // one host access as seen on the select and data lines
    typedef struct packed {
        logic [3:0] sel;
        logic [7:0] data;
    } vt_cmd_t;

endpackage

// ---- vt_video_timer.sv ----
// vt_video_timer: programmable crt video timing controller core
// assumes all inputs are synchronous to I_MCLK; the character carry is a
// one-cycle pulse from an external dot counter
`timescale 1ns/1ps

module vt_video_timer
    import vt_pkg::*;
(
    // clock and reset
    input  wire logic       I_MCLK,
    input  wire logic       I_RSTN,
    // host port
    input  wire logic       I_CS_N,
    input  wire logic       I_DS_N,
    input  wire logic [3:0] I_SEL,
    input  wire logic [7:0] I_DATA,
    // character rate carry from dot counter
    input  wire logic       I_CHAR_CLOCK_CARRY_IN,
    // refresh memory and character generator addressing
    output logic [7:0]      O_CHAR_COL,
    output logic [3:0]      O_SCAN_LINE,
    output logic [5:0]      O_DATA_ROW,
    // cursor marker
    output logic            O_CURSOR_VIDEO_OUT,
    // timing chain running
    output logic            O_RUNNING
);

    vt_cmd_t    host_cmd;                   // select and data together
    logic       ds_n_reg;                   // strobe delayed one cycle
    logic       wr_stb;                     // one-cycle write strobe
    logic [7:0] cfg_reg [VT_NUM_CFG];       // format control registers
    logic [7:0] cur_col_reg;                // cursor column
    logic [7:0] cur_row_reg;                // cursor row
    logic       run_reg;                    // timing chain running
    logic [7:0] h_cnt_reg;                  // character column
    logic [9:0] line_cnt_reg;               // scan within frame
    logic [3:0] scan_cnt_reg;               // scan within data row
    logic [5:0] lrow_reg;                   // data row count from top
    logic [5:0] drow_reg;                   // displayed (rotated) row
    logic       act_reg;                    // inside data rows
    logic       cur_vid_reg;                // cursor video
    logic       do_reset;                   // reset command taken
    logic       do_start;                   // start command taken
    logic       carry;                      // counting enabled this cycle
    logic       h_end;                      // last character of line
    logic [9:0] frame_total;                // scans per frame
    logic [9:0] line_next;                  // next scan in frame
    logic [3:0] spr_m1;                     // scans per row minus one
    logic [5:0] rows_m1;                    // rows per frame minus one
    logic [5:0] last_row;                   // last displayed row
    logic [5:0] first_row;                  // row shown at the top

    assign host_cmd = '{sel: I_SEL, data: I_DATA};

    // strobe edge detect; host holds select and data across the low edge
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            ds_n_reg <= 1'b1;
        else
            ds_n_reg <= I_DS_N;
    end

    assign wr_stb   = !I_CS_N && ds_n_reg && !I_DS_N;
    assign do_reset = wr_stb && host_cmd.sel == VT_SEL_RESET;
    assign do_start = wr_stb && host_cmd.sel == VT_SEL_START;

    // decoded format fields
    assign spr_m1      = cfg_reg[VT_CFG_ROWFMT][VT_SPR_MSB:VT_SPR_LSB];
    assign rows_m1     = cfg_reg[VT_CFG_ROWS][VT_ROWS_MSB:0];
    assign last_row    = cfg_reg[VT_CFG_LASTROW][VT_ROWS_MSB:0];
    assign frame_total = {1'b0, cfg_reg[VT_CFG_FRAME], 1'b0} + VT_FRAME_BASE;
    // top row follows the last displayed row
    assign first_row   = (last_row >= rows_m1) ? VT_ROW_RST : last_row + 6'h01;

    // format registers; scroll bumps the last row with wraparound
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            for (int i = 0; i < VT_NUM_CFG; i++)
                cfg_reg[i] <= VT_CFG_RST;
        end
        else if (wr_stb && host_cmd.sel <= VT_SEL_REG_LAST)
        begin
            cfg_reg[host_cmd.sel[2:0]] <= host_cmd.data;
        end
        else if (wr_stb && host_cmd.sel == VT_SEL_SCROLL)
        begin
            if (last_row >= rows_m1)
                cfg_reg[VT_CFG_LASTROW] <= VT_CFG_RST;
            else
                cfg_reg[VT_CFG_LASTROW] <= {2'b00, last_row + 6'h01};
        end
    end

    // cursor position registers
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            cur_col_reg <= VT_CUR_RST;
            cur_row_reg <= VT_CUR_RST;
        end
        else if (wr_stb)
        begin
            if (host_cmd.sel == VT_SEL_CUR_COL)
                cur_col_reg <= host_cmd.data;  // column load
            if (host_cmd.sel == VT_SEL_CUR_ROW)
                cur_row_reg <= host_cmd.data;  // row load
        end
    end

    // run flag; reset command wins over a stale start
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            run_reg <= 1'b0;
        else if (do_reset)
            run_reg <= 1'b0;
        else if (do_start)
            run_reg <= 1'b1;
    end

    // carries are dropped on a reset or start cycle so the restart is not disturbed
    assign carry     = run_reg && I_CHAR_CLOCK_CARRY_IN && !do_reset && !do_start;
    // count wraps after stored value plus one
    assign h_end     = h_cnt_reg == cfg_reg[VT_CFG_HTOTAL];
    assign line_next = (line_cnt_reg >= frame_total - 10'h001) ? VT_LINE_RST
                                                               : line_cnt_reg + 10'h001;

    // timing chain counters
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            h_cnt_reg    <= VT_H_RST;
            line_cnt_reg <= VT_LINE_RST;
            scan_cnt_reg <= VT_SCAN_RST;
            lrow_reg     <= VT_ROW_RST;
            drow_reg     <= VT_ROW_RST;
            act_reg      <= 1'b0;
        end
        else if (do_reset || do_start)
        begin
            // both commands restart the chain from the frame top
            h_cnt_reg    <= VT_H_RST;
            line_cnt_reg <= VT_LINE_RST;
            scan_cnt_reg <= VT_SCAN_RST;
            lrow_reg     <= VT_ROW_RST;
            drow_reg     <= first_row;
            act_reg      <= do_start && cfg_reg[VT_CFG_VSTART] == VT_CFG_RST;
        end
        else if (carry)
        begin
            if (!h_end)
            begin
                h_cnt_reg <= h_cnt_reg + 8'h01;
            end
            else
            begin
                h_cnt_reg    <= VT_H_RST;
                line_cnt_reg <= line_next;
                if (line_next == {2'b00, cfg_reg[VT_CFG_VSTART]})
                begin
                    scan_cnt_reg <= VT_SCAN_RST;
                    lrow_reg     <= VT_ROW_RST;
                    drow_reg     <= first_row;
                    act_reg      <= 1'b1;
                end
                else if (line_next == VT_LINE_RST)
                begin
                    scan_cnt_reg <= VT_SCAN_RST;
                    lrow_reg     <= VT_ROW_RST;
                    act_reg      <= 1'b0;
                end
                else if (act_reg)
                begin
                    if (scan_cnt_reg >= spr_m1)
                    begin
                        scan_cnt_reg <= VT_SCAN_RST;
                        if (lrow_reg >= rows_m1)
                            act_reg <= 1'b0;
                        else
                        begin
                            lrow_reg <= lrow_reg + 6'h01;
                            drow_reg <= (drow_reg >= rows_m1) ? VT_ROW_RST
                                                             : drow_reg + 6'h01;
                        end
                    end
                    else
                        scan_cnt_reg <= scan_cnt_reg + 4'h1;
                end
            end
        end
    end

    // cursor video, one cycle behind the counters it compares
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            cur_vid_reg <= 1'b0;
        else
            // match on column and displayed row; a reset command
            // blanks the marker at once rather than one clock later
            cur_vid_reg <= run_reg && !do_reset && act_reg && h_cnt_reg == cur_col_reg
                           && {2'b00, drow_reg} == cur_row_reg;
    end

    // outputs straight from the counters and the cursor and run flags
    assign O_CHAR_COL         = h_cnt_reg;
    assign O_SCAN_LINE        = scan_cnt_reg;
    assign O_DATA_ROW         = drow_reg;
    assign O_CURSOR_VIDEO_OUT = cur_vid_reg;
    assign O_RUNNING          = run_reg;

    // protocol and counter checks; all disabled while reset is held
    AST_RESET_STOPS: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        do_reset |=> (!run_reg && h_cnt_reg == VT_H_RST && !cur_vid_reg)[*2])
        else $error("reset command did not stop the chain");

    AST_CUR_COL_LOAD: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (wr_stb && I_SEL == VT_SEL_CUR_COL) |=> cur_col_reg == $past(I_DATA))
        else $error("cursor column not loaded");

    AST_CUR_ROW_LOAD: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (wr_stb && I_SEL == VT_SEL_CUR_ROW) |=> cur_row_reg == $past(I_DATA)
        && cur_col_reg == $past(cur_col_reg))
        else $error("cursor row not loaded");

    AST_START_RUNS: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (do_start && !do_reset) |=> run_reg && O_CHAR_COL == VT_H_RST)
        else $error("start did not run the chain");

    AST_H_WRAP: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (carry && h_end) |=> O_CHAR_COL == VT_H_RST)
        else $error("column did not wrap at stored count");

    AST_H_STEP: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (carry && !h_end) |=> O_CHAR_COL == $past(O_CHAR_COL) + 8'h01
        && $stable(O_SCAN_LINE) && $stable(O_DATA_ROW))
        else $error("column did not step on carry");

    AST_NO_CARRY_HOLD: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (!I_CHAR_CLOCK_CARRY_IN && !wr_stb) |=> $stable(O_CHAR_COL) && $stable(O_SCAN_LINE))
        else $error("counters moved without carry");

    AST_VSTART: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (carry && h_end && line_next == {2'b00, cfg_reg[VT_CFG_VSTART]})
        |=> act_reg && O_SCAN_LINE == VT_SCAN_RST && lrow_reg == VT_ROW_RST)
        else $error("data rows did not begin at vertical start");

    AST_ROW_BOUND: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        act_reg |-> lrow_reg <= rows_m1)
        else $error("row counter past last displayed row");

    AST_SCROLL: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (wr_stb && I_SEL == VT_SEL_SCROLL && last_row < rows_m1)
        |=> last_row == $past(last_row) + 6'h01)
        else $error("scroll did not rotate rows");

    AST_REG_LOAD: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (wr_stb && I_SEL <= VT_SEL_REG_LAST) |=> cfg_reg[$past(I_SEL[2:0])] == $past(I_DATA))
        else $error("format register not loaded");

    AST_CURSOR_VIDEO: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_CURSOR_VIDEO_OUT |-> $past(h_cnt_reg) == cur_col_reg || $past(wr_stb))
        else $error("cursor video away from cursor column");

endmodule // vt_video_timer
